// ---- hpp_port_regs.vh ----
`ifndef HPP_PORT_REGS_VH
`define HPP_PORT_REGS_VH

// Pin bus widths and register memory depth
`define HPP_ADDR_W        10
`define HPP_DATA_W        8
`define HPP_MEM_DEPTH     2048

// Register byte offsets on the bus
`define HPP_OFS_CTRL      12'h000
`define HPP_OFS_STATUS    12'h004
`define HPP_OFS_MEMADDR   12'h008
`define HPP_OFS_MEMDATA   12'h00C

// Control fields and reset value
`define HPP_CTRL_WREN     0
`define HPP_CTRL_RDEN     1
`define HPP_CTRL_RESET    2'h3

// Status fields
`define HPP_ST_SPI        0
`define HPP_ST_CPOL       1
`define HPP_ST_CPHA       2
`define HPP_ST_LSB        3
`define HPP_ST_CHAN       4
`define HPP_ST_CNT_LO     8

// Memory address fields
`define HPP_MA_CHAN       10

// Serial setting pin positions and defaults
`define HPP_PIN_CPOL      7
`define HPP_PIN_CPHA      6
`define HPP_PIN_SWAP      5
`define HPP_SPI_DEFAULT   1'b0

// Synchroniser idle levels
`define HPP_IDLE_HIGH     1'b1
`define HPP_IDLE_LOW      1'b0

`endif

// ---- hpp_cells.v ----
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
// Two-flop synchroniser, one chain per bit
module hpp_sync #(
    parameter          WIDTH     = 1,
    parameter          RESET_VAL = 1'b0
) (
    // Clock and reset
    input  wire             clk,
    input  wire             reset_n,
    // Asynchronous input and synchronised output
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gBit
            reg firstStage;   // Read only by second stage
            reg secondStage;  // Safe to use
            // Two flops per bit
            always @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    firstStage  <= RESET_VAL;
                    secondStage <= RESET_VAL;
                end else begin
                    firstStage  <= asyncIn[i];
                    secondStage <= firstStage;
                end
            end
            assign syncOut[i] = secondStage;
        end
    endgenerate
endmodule

////////////////////////////////////////////////////////////////////////////
// Edge finder on a synchronised level
module hpp_edge #(
    parameter          RESET_VAL = 1'b0
) (
    // Clock and reset
    input  wire clk,
    input  wire reset_n,
    // Level in, one-cycle pulses out
    input  wire level,
    output wire rise,
    output wire fall
);
    reg prevLevel;  // Level one cycle ago

    // Remember last level
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prevLevel <= RESET_VAL;
        end else begin
            prevLevel <= level;
        end
    end

    assign rise = level & ~prevLevel;
    assign fall = ~level & prevLevel;
endmodule

// ---- hpp_port.v ----
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`include "hpp_port_regs.vh"

////////////////////////////////////////////////////////////////////////////
// Host access port pin logic with an AHB-Lite register slave
module hpp_port (
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    // Host address pins
    input  wire        addressTopLine,
    input  wire [8:0]  addressLow,
    // Host data pins, split into in, out and enable
    input  wire [7:0]  dataIn,
    output reg  [7:0]  dataOut,
    output wire        dataOe,
    // Host strobes and selects, active low
    input  wire        channelOneSelectN,
    input  wire        channelTwoSelectN,
    input  wire        writeStrobeN,
    input  wire        readStrobeN,
    // Host port mode pin
    input  wire        serialSelect,
    // Serial settings for the serial engine
    output reg         serialClockPolarity,
    output reg         serialClockPhase,
    output reg         serialLsbFirst
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    // Register storage, two channels of one address space
    reg  [7:0]  mem [0:`HPP_MEM_DEPTH-1];

    wire [9:0]  addrSync;        // Synchronised address pins
    wire [7:0]  dataSync;        // Synchronised data pins
    wire        selOneN;         // Synchronised select one
    wire        selTwoN;         // Synchronised select two
    wire        wrN;             // Synchronised write strobe
    wire        rdN;             // Synchronised read strobe
    wire        spiMode;         // Synchronised mode pin
    wire        wrRise;          // Write strobe rising edge

    reg  [9:0]  addrHold;        // Address held while strobe low
    reg  [7:0]  dataHold;        // Data held while strobe low
    reg         chanHold;        // Channel held while strobe low
    reg         holdValid;       // One select was low in hold
    reg  [1:0]  ctrl;            // Write and read enables
    reg         lastChan;        // Channel of last pin write
    reg  [7:0]  writeCount;      // Pin writes counted
    reg  [10:0] memAddr;         // Bus window address
    reg         dpValid;         // Bus data phase pending
    reg         dpWrite;         // Pending phase is a write
    reg  [11:0] dpAddr;          // Pending phase offset
    reg         rdDone;          // Read data loaded

    wire        pinWrite;        // Pin write this cycle
    wire        oneSelected;     // Exactly one select low
    wire        busStall;        // Write clash with pin write
    wire        apTake;          // Address phase accepted
    wire        dpFinish;        // Data phase ends this cycle

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    // Address and data pins, idle low
    hpp_sync #(
        .WIDTH     (18),
        .RESET_VAL (`HPP_IDLE_LOW)
    ) uSyncBus (
        .clk     (clk),
        .reset_n (reset_n),
        .asyncIn ({addressTopLine, addressLow, dataIn}),
        .syncOut ({addrSync, dataSync})
    );

    // Strobes and selects, idle high
    hpp_sync #(
        .WIDTH     (4),
        .RESET_VAL (`HPP_IDLE_HIGH)
    ) uSyncStrobe (
        .clk     (clk),
        .reset_n (reset_n),
        .asyncIn ({channelOneSelectN, channelTwoSelectN,
                   writeStrobeN, readStrobeN}),
        .syncOut ({selOneN, selTwoN, wrN, rdN})
    );

    // Mode pin
    hpp_sync #(
        .WIDTH     (1),
        .RESET_VAL (`HPP_IDLE_LOW)
    ) uSyncMode (
        .clk     (clk),
        .reset_n (reset_n),
        .asyncIn (serialSelect),
        .syncOut (spiMode)
    );

    // Write strobe edges
    hpp_edge #(
        .RESET_VAL (`HPP_IDLE_HIGH)
    ) uWrEdge (
        .clk     (clk),
        .reset_n (reset_n),
        .level   (wrN),
        .rise    (wrRise),
        .fall    ()
    );

    ////////////////////////////////////////////////////////////////////////
    // Register index from pins

    // Channel bit above the ten address bits
    function [10:0] memIndex;
        input       chan;
        input [9:0] addr;
        begin
            memIndex = {chan, addr};
        end
    endfunction

    assign oneSelected = selOneN ^ selTwoN;

    ////////////////////////////////////////////////////////////////////////
    // Parallel write capture

    // Hold address, data and channel while write strobe low
    // The last low cycle wins, so late pin changes are what get stored
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            addrHold  <= 10'h000;
            dataHold  <= 8'h00;
            chanHold  <= 1'b0;
            holdValid <= 1'b0;
        end else if (!wrN) begin
            addrHold  <= addrSync;
            dataHold  <= dataSync;
            chanHold  <= ~selTwoN;
            holdValid <= oneSelected;
        end
    end

    // parallel writes only in parallel mode
    assign pinWrite = wrRise & holdValid & ~spiMode
                    & ctrl[`HPP_CTRL_WREN];

    // Memory write port, pin writes first
    // A pin write cannot be held off, so the bus write stalls instead
    always @(posedge clk) begin
        if (pinWrite) begin
            mem[memIndex(chanHold, addrHold)] <= dataHold;
        end else if (dpValid && dpWrite && dpFinish
                     && dpAddr == `HPP_OFS_MEMDATA) begin
            mem[memAddr] <= hwdata[7:0];
        end
    end

    // Last channel and write count
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lastChan   <= 1'b0;
            writeCount <= 8'h00;
        end else if (pinWrite) begin
            lastChan   <= chanHold;
            writeCount <= writeCount + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Parallel read drive

    // Read data from flops, refreshed every cycle
    // Output enable alone decides whether the pins see this value
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dataOut <= 8'h00;
        end else begin
            dataOut <= mem[memIndex(~selTwoN, addrSync)];
        end
    end

    // float unless exactly one select low
    // no parallel drive in serial mode
    assign dataOe = oneSelected & ~rdN & wrN & ~spiMode
                  & ctrl[`HPP_CTRL_RDEN];

    ////////////////////////////////////////////////////////////////////////
    // Serial settings from data pins

    // Taken only while idle in serial mode
    // While a select is low the pins carry a transfer, not settings
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            serialClockPolarity <= `HPP_SPI_DEFAULT;
            serialClockPhase    <= `HPP_SPI_DEFAULT;
            serialLsbFirst      <= `HPP_SPI_DEFAULT;
        end else if (spiMode && selOneN && selTwoN) begin
            serialClockPolarity <= dataSync[`HPP_PIN_CPOL];
            serialClockPhase    <= dataSync[`HPP_PIN_CPHA];
            // bit 5 high means LSB first
            serialLsbFirst      <= dataSync[`HPP_PIN_SWAP];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus slave handshake

    // Accepted address phase
    assign apTake   = hsel & htrans[1] & hready;
    // Write to memory window loses to a pin write
    assign busStall = dpValid & dpWrite & pinWrite
                    & (dpAddr == `HPP_OFS_MEMDATA);
    // Reads wait one cycle for loaded data
    assign hreadyout = ~busStall & ~(dpValid & ~dpWrite & ~rdDone);
    assign dpFinish  = hreadyout;
    // Always OKAY
    assign hresp     = 1'b0;

    // Data phase tracking
    // A read stays pending one extra cycle while its data loads
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dpValid <= 1'b0;
            dpWrite <= 1'b0;
            dpAddr  <= 12'h000;
            rdDone  <= 1'b0;
        end else if (hready) begin
            dpValid <= apTake;
            dpWrite <= hwrite;
            dpAddr  <= {haddr[11:2], 2'b00};
            rdDone  <= 1'b0;
        end else if (dpValid && !dpWrite) begin
            rdDone  <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus register writes

    // Control and window address
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl    <= `HPP_CTRL_RESET;
            memAddr <= 11'h000;
        end else if (dpValid && dpWrite && dpFinish) begin
            if (dpAddr == `HPP_OFS_CTRL) begin
                ctrl    <= hwdata[1:0];
            end else if (dpAddr == `HPP_OFS_MEMADDR) begin
                memAddr <= hwdata[10:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus register reads

    // Load read data in the wait cycle
    // Loading once keeps hrdata steady through the ready cycle
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata <= 32'h0000_0000;
        end else if (dpValid && !dpWrite && !rdDone) begin
            if (dpAddr == `HPP_OFS_CTRL) begin
                hrdata <= {30'h0000_0000, ctrl};
            end else if (dpAddr == `HPP_OFS_STATUS) begin
                hrdata <= {16'h0000, writeCount, 3'h0, lastChan,
                           serialLsbFirst, serialClockPhase,
                           serialClockPolarity, spiMode};
            end else if (dpAddr == `HPP_OFS_MEMADDR) begin
                hrdata <= {21'h00_0000, memAddr};
            end else if (dpAddr == `HPP_OFS_MEMDATA) begin
                hrdata <= {24'h00_0000, mem[memAddr]};
            end else begin
                // Unmapped reads as zero
                hrdata <= 32'h0000_0000;
            end
        end
    end

endmodule

// ---- hpp_port_properties.sv ----
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
// Pin and bus checker for the host port
module hpp_port_properties (
    // Clock and reset
    input wire       clk,
    input wire       reset_n,
    // Bus request and answer
    input wire       hsel,
    input wire [1:0] htrans,
    input wire       hwrite,
    input wire       hready,
    input wire       hreadyout,
    // Host pins
    input wire [7:0] dataIn,
    input wire       dataOe,
    input wire       channelOneSelectN,
    input wire       channelTwoSelectN,
    input wire       serialSelect,
    // Serial settings
    input wire       serialClockPolarity,
    input wire       serialClockPhase,
    input wire       serialLsbFirst
);
    // One clock domain
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Both selects high long enough to pass the synchroniser
    sequence bothIdle;
        (channelOneSelectN && channelTwoSelectN)[*4];
    endsequence
    // Serial mode, no select, data pins steady
    sequence setSteady;
        (serialSelect && channelOneSelectN && channelTwoSelectN
            && $stable(dataIn))[*5];
    endsequence
    // Bus transfer taken
    sequence taken;
        hsel && htrans[1] && hready;
    endsequence

    a_bus_float: assert property (bothIdle |-> !dataOe)
        else $error("data bus driven while deselected");
    a_both_low: assert property (
        (!channelOneSelectN && !channelTwoSelectN)[*4] |-> !dataOe)
        else $error("data bus driven with both selects low");
    a_serial_nodrive: assert property (serialSelect[*4] |-> !dataOe)
        else $error("data bus driven in serial mode");
    a_cpol_pin: assert property (
        setSteady |-> serialClockPolarity == dataIn[7])
        else $error("polarity not taken from bit 7");
    a_cpha_pin: assert property (
        setSteady |-> serialClockPhase == dataIn[6])
        else $error("phase not taken from bit 6");
    a_order_pin: assert property (
        setSteady |-> serialLsbFirst == dataIn[5])
        else $error("bit order not taken from bit 5");
    a_parallel_hold: assert property ((!serialSelect)[*5] |->
        $stable({serialClockPolarity, serialClockPhase,
        serialLsbFirst}))
        else $error("serial settings moved in parallel mode");
    a_read_ready: assert property (taken and !hwrite |=>
        !hreadyout ##1 hreadyout)
        else $error("read answer timing wrong");
    a_write_ready: assert property (taken and hwrite |=>
        ##[0:1] hreadyout)
        else $error("write answer too late");
endmodule

bind hpp_port hpp_port_properties chk (.*);

// ---- hpp_host_model.sv ----
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
// Host processor on the parallel pins
module hpp_host_model (
    // Clock
    input  wire       clk,
    // Device data drive
    input  wire [7:0] dataOut,
    input  wire       dataOe,
    // Pins to the device
    output reg        addressTopLine,
    output reg  [8:0] addressLow,
    output wire [7:0] dataIn,
    output reg        channelOneSelectN,
    output reg        channelTwoSelectN,
    output reg        writeStrobeN,
    output reg        readStrobeN,
    output reg        serialSelect
);
    reg       hostOe;   // Host drives data pins
    reg [7:0] hostData; // Host data value
    reg [7:0] lastVal;  // Last driven wire level

    // Floating bus shows the inverse of the last level
    assign dataIn = hostOe ? hostData : dataOe ? dataOut : ~lastVal;

    // Track the wire while someone drives it
    always @(posedge clk) begin
        if (hostOe || dataOe) begin
            lastVal <= dataIn;
        end
    end

    // Idle pins at time zero
    initial begin
        {addressTopLine, addressLow, hostOe, hostData} = '0;
        {serialSelect, lastVal} = '0;
        {channelOneSelectN, channelTwoSelectN} = 2'h3;
        {writeStrobeN, readStrobeN} = 2'h3;
    end

    task automatic access(input [1:0] selN, input [9:0] a);
        {channelTwoSelectN, channelOneSelectN} <= selN;
        {addressTopLine, addressLow} <= a;
    endtask

    task automatic pin_write(input [1:0] selN, input [9:0] a,
                             input [7:0] d);
        access(selN, a);
        hostOe <= 1'b1;
        hostData <= d;
        writeStrobeN <= 1'b0;
        repeat (3) @(posedge clk);
        writeStrobeN <= 1'b1;
        repeat (4) @(posedge clk);
        release_bus;
    endtask

    // Read cycle, sampled mid-cycle
    task automatic pin_read(input [1:0] selN, input [9:0] a,
                            output [7:0] q, output oe);
        access(selN, a);
        readStrobeN <= 1'b0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        q = dataIn;
        oe = dataOe;
        @(posedge clk);
    endtask

    task automatic release_bus;
        {channelTwoSelectN, channelOneSelectN} <= 2'h3;
        {writeStrobeN, readStrobeN} <= 2'h3;
        // settings pins stay driven in serial mode
        hostOe <= serialSelect;
        repeat (3) @(posedge clk);
    endtask

    task automatic set_serial(input s, input [7:0] d);
        serialSelect <= s;
        hostOe <= 1'b1;
        hostData <= d;
        repeat (5) @(posedge clk);
    endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/100ps
`include "hpp_port_regs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin nMismatch++; \
    $display("ERROR %0t: got %h want %h", $time, g, e); end end

////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the host port
module testbench;
    // Clock, reset and counters
    logic        clk;
    logic        reset_n;
    int          nMismatch;
    int          checked;
    // Bus master
    logic        hsel;
    logic        hwrite;
    logic [1:0]  htrans;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] q;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         hresp;
    // Pins
    wire  [7:0]  dataIn;
    wire  [7:0]  dataOut;
    wire  [8:0]  addressLow;
    wire         addressTopLine;
    wire         dataOe;
    wire         channelOneSelectN;
    wire         channelTwoSelectN;
    wire         writeStrobeN;
    wire         readStrobeN;
    wire         serialSelect;
    wire         serialClockPolarity;
    wire         serialClockPhase;
    wire         serialLsbFirst;

    hpp_port dut (.hsize(3'h2), .hready(hreadyout), .*);
    hpp_host_model host (.*);

    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Wait for ready, bounded
    task automatic wait_rdy(output logic [31:0] d);
        int n;
        logic r;
        n = 0;
        do begin
            @(negedge clk);
            r = hreadyout;
            d = hrdata;
            @(posedge clk);
            n++;
        end while (r !== 1'b1 && n < 40);
        if (r !== 1'b1) begin
            nMismatch++;
            tally_and_finish;
        end
    endtask

    // One single word transfer
    task automatic ahb(input bit w, input [31:0] a, input [31:0] d,
                       output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_rdy(r);
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy(r);
    endtask

    // Read one memory byte over the bus
    task automatic peek(input [10:0] a, input [7:0] e);
        ahb(1, `HPP_OFS_MEMADDR, {21'h0, a}, q);
        ahb(0, `HPP_OFS_MEMDATA, 32'h0, q);
        `CHK(q[7:0], e)
    endtask

    // Reset values and an unmapped read
    task automatic t_regs;
        ahb(0, `HPP_OFS_CTRL, 32'h0, q);
        `CHK(q, 32'h0000_0003)
        ahb(0, `HPP_OFS_STATUS, 32'h0, q);
        `CHK(q, 32'h0000_0000)
        ahb(0, 32'h0000_0010, 32'h0, q);
        `CHK(q, 32'h0000_0000)
        `CHK(hresp, 1'b0)
    endtask

    // Pin writes to both channels, one refused
    task automatic t_write;
        host.pin_write(2'b10, 10'h355, 8'hA5);
        host.pin_write(2'b01, 10'h0AA, 8'h5A);
        host.pin_write(2'b00, 10'h355, 8'hFF);
        peek(11'h355, 8'hA5);
        peek(11'h4AA, 8'h5A);
        ahb(0, `HPP_OFS_STATUS, 32'h0, q);
        `CHK(q[15:8], 8'h02)
        `CHK(q[4], 1'b1)
    endtask

    // Pin read drives, then floats
    task automatic t_read;
        logic [7:0] d;
        logic       oe;
        ahb(1, `HPP_OFS_MEMADDR, 32'h0000_07FF, q);
        ahb(1, `HPP_OFS_MEMDATA, 32'h0000_003C, q);
        host.pin_read(2'b01, 10'h3FF, d, oe);
        `CHK(oe, 1'b1)
        `CHK(d, 8'h3C)
        host.release_bus;
        @(negedge clk);
        `CHK(dataOe, 1'b0)
        @(posedge clk);
    endtask

    // Serial settings from data bits 7, 6, 5
    task automatic t_serial;
        logic [7:0] d;
        logic       oe;
        for (int i = 0; i < 8; i++) begin
            host.set_serial(1'b1, {i[2:0], 5'h0A});
            `CHK({serialClockPolarity, serialClockPhase,
                serialLsbFirst}, i[2:0])
        end
        ahb(0, `HPP_OFS_STATUS, 32'h0, q);
        `CHK(q[3:0], 4'hF)
        host.pin_read(2'b10, 10'h000, d, oe);
        `CHK(oe, 1'b0)
        host.release_bus;
        host.set_serial(1'b0, 8'h00);
        `CHK({serialClockPolarity, serialClockPhase,
            serialLsbFirst}, 3'h7)
    endtask

    // Verdict and end of run
    task automatic tally_and_finish;
        if (nMismatch == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Main sequence
    initial begin
        reset_n = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        nMismatch = 0;
        checked = 0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_regs;
        t_write;
        t_read;
        t_serial;
        tally_and_finish;
    end
endmodule
